// >>> verilog/hwp_playback_ctrl.sv
// Waveform playback controller: FIFO streaming and RAM playback
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module hwp_playback_ctrl #(
    parameter int FIFO_DEPTH = hwp_pkg::RAM_WORDS,    // Queue depth in RAM words
    parameter int TICK_CYCLES = hwp_pkg::TICK_CYC     // Clocks per output tick
) (
    input  wire logic                        clock,
    input  wire logic                        rst_b,
    input  wire logic [hwp_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [hwp_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [hwp_pkg::DATA_W-1:0]  regRdData,
    input  wire logic                        senseDetect,
    output logic      [hwp_pkg::SMP_W-1:0]   sampleOut,
    output logic                             outputDrive
);
    import hwp_pkg::*;

    initial begin
        if (FIFO_DEPTH < 2 || FIFO_DEPTH > RAM_WORDS || TICK_CYCLES < 1) begin
            $error("hwp_playback_ctrl: unsupported parameter value");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage and state
    logic [DATA_W-1:0]  ram [RAM_WORDS];          // Shared waveform RAM / queue
    logic [8:0]         config_;                  // Mode, rate, drive and sense bits
    logic [RAM_AW-1:0]  ramAddr;                  // Burst write pointer
    logic [RAM_AW-1:0]  pbStart;                  // Staged start address
    logic [RAM_AW-1:0]  pbRepeat;                 // Staged repeat-start address
    logic [4:0]         readback_pointer;         // Indirect read selector
    logic [RAM_AW-1:0]  loopStart;                // Active repeat-start
    logic [RAM_AW-1:0]  endAddr;                  // Active end address, inclusive
    logic               loop_flag;                // Active loop flag
    logic [RAM_AW-1:0]  ptr;                      // RAM read pointer
    hwp_state_t         state;
    logic [RAM_AW-1:0]  wrPtr;                    // Queue write pointer
    logic [RAM_AW-1:0]  rdPtr;                    // Queue read pointer
    logic [RAM_AW:0]    count;                    // Queued entries
    logic               fifoActive;               // Queue draining
    logic               playback_done_flag;       // Sticky completion flag
    logic               senseMeta;                // Synchroniser stage one
    logic               senseSync;                // Synchroniser stage two
    logic [15:0]        tickCnt;                  // Output tick divider
    logic               tick;
    logic [6:0]         phase;                    // Sub-sample phase
    logic [SMP_W-1:0]   prevSmp;                  // Previous fetched sample
    logic [SMP_W-1:0]   curSmp;                   // Current fetched sample

    logic [1:0]         mode;
    logic [2:0]         rateSel;
    logic               senseGate;
    logic               sampleTick;
    logic               cmdWr;
    logic               push;
    logic               pop;
    logic               ramFinish;
    logic               fifoEmptyHit;
    logic [RAM_AW:0]    freeSpace;
    logic [RAM_AW-1:0]  next_end;
    logic [RAM_AW-1:0]  next_loopStart;
    logic               next_loop;

    assign mode      = config_[CFG_MODE +: 2];
    assign rateSel   = config_[CFG_RATE +: 3];
    assign senseGate = config_[CFG_AUTO] & config_[CFG_COMP] & config_[CFG_SENSE];
    assign cmdWr     = regWr && regAddr == REG_PBCMD;
    assign freeSpace = (RAM_AW+1)'(FIFO_DEPTH) - count;
    assign push      = regWr && regAddr == REG_SAMPLE && mode == MODE_FIFO
                       && freeSpace != '0;
    assign pop       = sampleTick && fifoActive && count != '0;
    assign fifoEmptyHit = sampleTick && fifoActive && count == '0;
    assign ramFinish = sampleTick && state == PB_PLAY && ptr == next_end && !next_loop;
    assign sampleTick = tick && phase == 7'((8'h01 << rateSel) - 8'h01);

    // Follow-on commands retarget the running pass; start field ignored
    assign next_end       = cmdWr ? regWrData[RAM_AW-1:0] : endAddr;
    assign next_loop      = cmdWr ? regWrData[CMD_LOOP] : loop_flag;
    assign next_loopStart = (cmdWr && regWrData[CMD_LOOP]) ? pbRepeat : loopStart;

    // Pointer step with wrap at queue depth
    function automatic logic [RAM_AW-1:0] qInc(input logic [RAM_AW-1:0] p);
        qInc = (p == RAM_AW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sense input synchroniser; only the second stage is read
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            senseMeta <= 1'b0;
            senseSync <= 1'b0;
        end else begin
            senseMeta <= senseDetect;
            senseSync <= senseMeta;
        end
    end

    // Output tick divider and sub-sample phase
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tickCnt <= '0;
            tick    <= 1'b0;
            phase   <= '0;
        end else begin
            tick    <= tickCnt == 16'(TICK_CYCLES - 1);
            tickCnt <= (tickCnt == 16'(TICK_CYCLES - 1)) ? '0 : tickCnt + 1'b1;
            if (sampleTick) begin
                phase <= '0;
            end else if (tick) begin
                phase <= phase + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; hardware clears drive enable at RAM playback end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            config_          <= CFG_RESET;
            ramAddr          <= '0;
            pbStart          <= '0;
            pbRepeat         <= '0;
            readback_pointer <= '0;
        end else begin
            if (regWr && regAddr == REG_CONFIG) begin
                config_ <= regWrData[8:0];
            end else if (ramFinish) begin
                config_[CFG_OE] <= 1'b0;
            end else if (state == PB_ARMED && config_[CFG_OE] && senseGate && senseSync) begin
                config_[CFG_AUTO]  <= 1'b0;  // Auto and sense are one-shot
                config_[CFG_SENSE] <= 1'b0;
            end
            if (regWr && regAddr == REG_RAMADDR) begin
                ramAddr <= regWrData[RAM_AW-1:0];
            end else if (regWr && regAddr == REG_RAMDATA) begin
                ramAddr <= ramAddr + 1'b1;   // Burst write auto-increment
            end
            if (regWr && regAddr == REG_PBSTART) begin
                pbStart <= regWrData[RAM_AW-1:0];
            end
            if (regWr && regAddr == REG_PBRPT) begin
                pbRepeat <= regWrData[RAM_AW-1:0];
            end
            if (regWr && regAddr == REG_IFCTL) begin
                readback_pointer <= regWrData[4:0];
            end
        end
    end

    // RAM writes: burst load or queue append
    always_ff @(posedge clock) begin
        if (regWr && regAddr == REG_RAMDATA) begin
            ram[ramAddr] <= regWrData;
        end else if (push) begin
            ram[wrPtr] <= {4'h0, regWrData[SMP_W-1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue pointers; draining continues after drive is cleared
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrPtr      <= '0;
            rdPtr      <= '0;
            count      <= '0;
            fifoActive <= 1'b0;
        end else begin
            if (push) begin
                wrPtr <= qInc(wrPtr);
            end
            if (pop) begin
                rdPtr <= qInc(rdPtr);
            end
            count <= count + (RAM_AW+1)'(push) - (RAM_AW+1)'(pop);
            // Stay active until a sample tick finds the queue empty, so the
            // done flag is raised on that tick, on the same edge that draining stops
            if (config_[CFG_OE] && mode == MODE_FIFO) begin
                fifoActive <= 1'b1;
            end else if (fifoEmptyHit) begin
                fifoActive <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RAM playback sequencer
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state     <= PB_IDLE;
            ptr       <= '0;
            endAddr   <= '0;
            loopStart <= '0;
            loop_flag <= 1'b0;
        end else begin
            endAddr   <= next_end;
            loop_flag <= next_loop;
            loopStart <= next_loopStart;
            unique case (state)
                PB_IDLE, PB_ARMED: begin
                    if (cmdWr) begin
                        ptr       <= pbStart;
                        loopStart <= pbRepeat;
                        state     <= PB_ARMED;
                    end else if (state == PB_ARMED && mode == MODE_RAM
                                 && config_[CFG_OE] && (!senseGate || senseSync)) begin
                        state <= PB_PLAY;
                    end
                end
                PB_PLAY: begin
                    if (sampleTick) begin
                        if (ptr != next_end) begin
                            ptr <= ptr + 1'b1;
                        end else if (next_loop) begin
                            ptr <= next_loopStart;
                        end else begin
                            state <= PB_IDLE;
                        end
                    end
                end
                default: state <= PB_IDLE;
            endcase
        end
    end

    // Sample fetch; an empty source holds the last level
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prevSmp <= '0;
            curSmp  <= '0;
        end else if (sampleTick) begin
            prevSmp <= curSmp;
            if (state == PB_PLAY) begin
                curSmp <= ram[ptr][SMP_W-1:0];
            end else if (pop) begin
                curSmp <= ram[rdPtr][SMP_W-1:0];
            end
        end
    end

    // Linear interpolation across the sample period
    always_ff @(posedge clock) begin
        logic signed [12:0] diff;
        logic signed [20:0] part;
        diff = $signed({1'b0, curSmp}) - $signed({1'b0, prevSmp});
        part = (diff * $signed({1'b0, phase})) >>> rateSel;
        if (!rst_b) begin
            sampleOut <= '0;
        end else if (tick) begin
            sampleOut <= (rateSel == 3'h0) ? curSmp
                         : SMP_W'($signed({1'b0, prevSmp}) + part);
        end
    end

    // Done flag: hardware set wins over software clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            playback_done_flag <= 1'b0;
        end else if (ramFinish || fifoEmptyHit) begin
            playback_done_flag <= 1'b1;
        end else if (regWr && regAddr == REG_STATUS && regWrData[ST_DONE]) begin
            playback_done_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    function automatic logic [DATA_W-1:0] rdMux(input logic [7:0] a);
        unique case (a)
            REG_CONFIG:  rdMux = {7'h00, config_};
            REG_RAMADDR: rdMux = {6'h00, ramAddr};
            REG_PBSTART: rdMux = {6'h00, pbStart};
            REG_PBRPT:   rdMux = {6'h00, pbRepeat};
            REG_PBCMD:   rdMux = {5'h00, loop_flag, endAddr};
            REG_IFCTL:   rdMux = {11'h000, readback_pointer};
            REG_FIFOST:  rdMux = {freeSpace == '0, 4'h0, freeSpace};
            REG_STATUS:  rdMux = {13'h0000, fifoActive, state == PB_PLAY, playback_done_flag};
            default:     rdMux = '0;
        endcase
    endfunction

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= (regAddr == REG_READBK) ? rdMux({3'h0, readback_pointer})
                                                 : rdMux(regAddr);
        end else begin
            regRdData <= '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            outputDrive <= 1'b0;
        end else begin
            outputDrive <= state == PB_PLAY || fifoActive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    fifo_space_a: assert property (regRd && regAddr == REG_FIFOST |=>
        regRdData[RAM_AW:0] == (RAM_AW+1)'(FIFO_DEPTH) - $past(count))
        else $error("free space mismatch");
    oe_clear_a: assert property (ramFinish && !(regWr && regAddr == REG_CONFIG)
        |=> !config_[CFG_OE]) else $error("drive enable not cleared");
    done_set_a: assert property (fifoEmptyHit |=> playback_done_flag)
        else $error("done flag not set on empty queue");
    loop_wrap_a: assert property (state == PB_PLAY && sampleTick && ptr == next_end
        && next_loop |=> ptr == $past(next_loopStart) && state == PB_PLAY)
        else $error("loop did not wrap");
    ptr_step_a: assert property (state == PB_PLAY && sampleTick && ptr != next_end
        |=> ptr == $past(ptr) + 1'b1) else $error("pointer step wrong");
    sense_wait_a: assert property (state == PB_ARMED && senseGate && !senseSync
        && !cmdWr |=> state != PB_PLAY) else $error("started without detection");
    no_replay_a: assert property (state == PB_IDLE && !cmdWr |=> state != PB_PLAY)
        else $error("replay without command");
    push_count_a: assert property (push && !pop |=> count == $past(count) + 1'b1)
        else $error("queue count wrong");
    drain_a: assert property (fifoActive && count != '0 ##1 !config_[CFG_OE]
        |-> fifoActive) else $error("queue stopped draining");
    immediate_a: assert property (cmdWr && config_[CFG_OE] && mode == MODE_RAM
        && !senseGate && !(regWr && regAddr == REG_CONFIG) && state != PB_PLAY
        |=> ##1 state == PB_PLAY) else $error("immediate start missing");

    loop_cov_c: cover property (state == PB_PLAY && sampleTick && ptr == endAddr && loop_flag);
    finish_cov_c: cover property (ramFinish);
    empty_cov_c: cover property (fifoEmptyHit);
    full_cov_c: cover property (freeSpace == '0);
endmodule
`default_nettype wire

// >>> verilog/hwp_pkg.sv
// Constants shared by the haptic waveform playback controller
package hwp_pkg;
    localparam int          ADDR_W      = 8;             // Register address width
    localparam int          DATA_W      = 16;            // Register data width
    localparam int          RAM_WORDS   = 1024;          // Waveform RAM depth
    localparam int          RAM_AW      = 10;            // RAM address width
    localparam int          SMP_W       = 12;            // Sample width
    // Register offsets
    localparam logic [7:0]  REG_CONFIG  = 8'h00;
    localparam logic [7:0]  REG_SAMPLE  = 8'h01;
    localparam logic [7:0]  REG_RAMADDR = 8'h02;
    localparam logic [7:0]  REG_RAMDATA = 8'h03;
    localparam logic [7:0]  REG_PBSTART = 8'h04;
    localparam logic [7:0]  REG_PBRPT   = 8'h05;
    localparam logic [7:0]  REG_PBCMD   = 8'h06;
    localparam logic [7:0]  REG_IFCTL   = 8'h07;
    localparam logic [7:0]  REG_READBK  = 8'h08;
    localparam logic [7:0]  REG_FIFOST  = 8'h11;
    localparam logic [7:0]  REG_STATUS  = 8'h12;
    // CONFIG fields
    localparam int          CFG_OE      = 0;
    localparam int          CFG_MODE    = 1;             // Two bits
    localparam int          CFG_RATE    = 3;             // Three bits
    localparam int          CFG_AUTO    = 6;
    localparam int          CFG_COMP    = 7;
    localparam int          CFG_SENSE   = 8;
    localparam logic [8:0]  CFG_RESET   = 9'h000;
    localparam logic [1:0]  MODE_FIFO   = 2'h1;
    localparam logic [1:0]  MODE_RAM    = 2'h2;
    // Other fields
    localparam int          CMD_LOOP    = 10;            // Loop flag in command word
    localparam int          FST_FULL    = 15;            // Full flag in FIFO state
    localparam int          ST_DONE     = 0;
    localparam int          ST_PLAY     = 1;
    localparam int          ST_FIFO     = 2;
    // Output tick period and its cycle count at 200 MHz
    localparam int          CLK_MHZ     = 200;
    localparam int          TICK_NS     = 1000;
    localparam int          TICK_CYC    = TICK_NS * CLK_MHZ / 1000;
    typedef enum logic [1:0] {
        PB_IDLE  = 2'b00,
        PB_ARMED = 2'b01,
        PB_PLAY  = 2'b10
    } hwp_state_t;
endpackage

// >>> test/hwp_host_model.sv
// Host-side register master for the playback controller's register port
`timescale 1ns/1ps
`default_nettype none
module hwp_host_model (
    input  wire logic                        clock,     // System clock
    output logic      [hwp_pkg::ADDR_W-1:0]  regAddr,   // Register address
    output logic      [hwp_pkg::DATA_W-1:0]  regWrData, // Write data
    output logic                             regWr,     // Write strobe
    output logic                             regRd,     // Read strobe
    input  wire logic [hwp_pkg::DATA_W-1:0]  regRdData  // Read data
);
    import hwp_pkg::*;

    // Quiet bus at time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle write; idle data is inverted so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask

    // One-cycle read; data is taken in the single cycle it stands
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask

    // Sample push that checks queue state first, never overfills
    task automatic push(input logic [11:0] s, output logic ok);
        logic [15:0] st;
        wr(REG_IFCTL, 16'h0011);
        rd(REG_READBK, st);
        ok = (st[FST_FULL] === 1'b0) && (st[10:0] !== 11'h000);
        if (ok) begin
            wr(REG_SAMPLE, {4'h0, s});
        end
    endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking testbench for the haptic waveform playback controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hwp_pkg::*;
    typedef struct {logic [7:0] addr; logic [15:0] exp;} hwp_row_t;
    logic        clock = 1'b0;       // 200 MHz clock
    logic        rst_b = 1'b0;       // Active-low reset
    logic        senseDetect = 1'b0; // Sense level
    logic [7:0]  regAddr;            // Bus from host model
    logic [15:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [15:0] regRdData;
    logic [11:0] sampleOut;
    logic        outputDrive;
    int          miscompares = 0;    // Mismatch count
    int          cmp_count = 0;      // Comparison count
    logic [11:0] cap[$];             // Samples seen while driving
    logic [11:0] exq[$];             // Expected sample order
    logic [11:0] lastS = 12'h000;
    logic [2:0]  driveHist = 3'h0;   // Recent drive levels; output lags drive
    logic [15:0] d;
    logic        ok;
    int          k;
    // Reset-state reads, including an unmapped address
    hwp_row_t rows [4] = '{'{REG_FIFOST, 16'h0008}, '{REG_STATUS, 16'h0000},
                           '{REG_CONFIG, 16'h0000}, '{8'h1f, 16'h0000}};

    always #2.5 clock = ~clock;

    // Small depth and short tick keep the run brief
    hwp_playback_ctrl #(.FIFO_DEPTH(8), .TICK_CYCLES(2)) hwp_playback_ctrl_inst (
        .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .senseDetect(senseDetect), .sampleOut(sampleOut), .outputDrive(outputDrive));
    hwp_host_model hwp_host_model_inst (
        .clock(clock), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData));

    ////////////////////////////////////////////////////////////////////////
    // Record each new output value while drive is (or just was) high
    always @(posedge clock) begin
        if ((outputDrive || driveHist != 3'h0) && sampleOut !== lastS) begin
            cap.push_back(sampleOut);
        end
        lastS <= sampleOut;
        driveHist <= {driveHist[1:0], outputDrive};
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        hwp_host_model_inst.wr(a, v);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        hwp_host_model_inst.rd(a, v);
    endtask
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // Captured samples from base on must match the expected order
    task automatic checkSeq(input int base);
        repeat (6) @(posedge clock);  // Last sample shows after drive falls
        foreach (exq[i]) check("sample", {4'h0, exq[i]}, {4'h0, cap[base+i]});
    endtask
    // Bounded wait for drive to reach a level
    task automatic waitDrive(input logic lvl);
        int n;
        n = 0;
        while (outputDrive !== lvl && n < 3000) begin
            @(posedge clock);
            #1 n++;
        end
        check("outputDrive", {15'h0, lvl}, {15'h0, outputDrive});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short
    initial begin
        #300000;
        miscompares++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        #1 check("reset drive", 16'h0, {15'h0, outputDrive});
        check("reset sample", 16'h0, {4'h0, sampleOut});
        foreach (rows[i]) begin
            rd(rows[i].addr, d);
            check("reset read", rows[i].exp, d);
        end
        // Queue mode: prefill to full with drive off, then overfill
        wr(REG_CONFIG, 16'h0002);
        for (int i = 0; i < 8; i++) hwp_host_model_inst.push(12'h200 + i[11:0], ok);
        rd(REG_FIFOST, d);
        check("fifo full", 16'h8000, d);
        wr(REG_SAMPLE, 16'h0777);
        rd(REG_FIFOST, d);
        check("fifo refused", 16'h8000, d);
        cap.delete();
        wr(REG_CONFIG, 16'h0003);
        waitDrive(1'b1);
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) hwp_host_model_inst.push(12'h000, ok);
        wr(REG_CONFIG, 16'h0002);
        waitDrive(1'b0);
        check("held sample", 16'h0000, {4'h0, sampleOut});
        rd(REG_STATUS, d);
        check("done flag", 16'h1, {15'h0, d[ST_DONE]});
        exq = '{12'h200, 12'h201, 12'h202, 12'h203, 12'h204, 12'h205, 12'h206, 12'h207,
                12'h000};
        checkSeq(0);
        wr(REG_STATUS, 16'h0001);
        // Load RAM while idle
        wr(REG_CONFIG, 16'h0004);
        wr(REG_RAMADDR, 16'h0000);
        for (int i = 0; i < 16; i++) wr(REG_RAMDATA, 16'h0100 + i[15:0]);
        // Immediate start: drive on before the command
        cap.delete();
        wr(REG_CONFIG, 16'h0005);
        wr(REG_PBSTART, 16'h0002);
        wr(REG_PBRPT, 16'h0002);
        wr(REG_PBCMD, 16'h0005);
        waitDrive(1'b1);
        waitDrive(1'b0);
        exq = '{12'h102, 12'h103, 12'h104, 12'h105};
        checkSeq(0);
        rd(REG_CONFIG, d);
        check("drive self-clear", 16'h0004, d);
        repeat (40) @(posedge clock);
        #1 check("no replay", 16'h0, {15'h0, outputDrive});
        // Triggered looping playback, then a stop with an extension
        cap.delete();
        wr(REG_PBSTART, 16'h0001);
        wr(REG_PBRPT, 16'h0003);
        wr(REG_PBCMD, 16'h0404);
        repeat (20) @(posedge clock);
        #1 check("armed idle", 16'h0, {15'h0, outputDrive});
        wr(REG_CONFIG, 16'h0005);
        for (int i = 0; i < 500 && cap.size() < 6; i++) @(posedge clock);
        wr(REG_PBCMD, 16'h0006);
        waitDrive(1'b0);
        exq = '{12'h101, 12'h102, 12'h103, 12'h104, 12'h103, 12'h104};
        checkSeq(0);
        k = 0;
        foreach (cap[i]) if (k == 0 && cap[i] === 12'h105) k = i;
        exq = '{12'h104, 12'h105, 12'h106};
        checkSeq(k - 1);
        rd(REG_CONFIG, d);
        check("drive self-clear", 16'h0004, d);
        // Sense-gated start
        cap.delete();
        wr(REG_PBSTART, 16'h0007);
        wr(REG_PBRPT, 16'h0007);
        wr(REG_PBCMD, 16'h0008);
        wr(REG_CONFIG, 16'h01c5);
        repeat (30) @(posedge clock);
        #1 check("sense wait", 16'h0, {15'h0, outputDrive});
        senseDetect <= 1'b1;
        waitDrive(1'b1);
        senseDetect <= 1'b0;
        waitDrive(1'b0);
        exq = '{12'h107, 12'h108};
        checkSeq(0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
